// ### rtl/uart_regs_pkg.sv
// Constants, field layouts and state types for one serial channel's register map and FIFOs
package uart_regs_pkg;

  // FIFO geometry
  localparam int             FIFO_DEPTH = 64;
  localparam int             PTR_W      = 6;
  localparam int             CNT_W      = 7;
  localparam int             ENTRY_W    = 11;
  localparam logic [CNT_W-1:0] CAP_FIFO = 7'h40;
  localparam logic [CNT_W-1:0] CAP_ONE  = 7'h01;

  // Register offsets on the three address lines
  localparam logic [2:0] OFS_DATA       = 3'h0;
  localparam logic [2:0] OFS_IRQ_EN     = 3'h1;
  localparam logic [2:0] OFS_FIFO_CTL   = 3'h2;
  localparam logic [2:0] OFS_FORMAT     = 3'h3;
  localparam logic [2:0] OFS_PIN_CTL    = 3'h4;
  localparam logic [2:0] OFS_LINE_STATE = 3'h5;
  localparam logic [2:0] OFS_PIN_STATE  = 3'h6;
  localparam logic [2:0] OFS_SCRATCH    = 3'h7;

  // Bank key and field positions
  localparam logic [7:0] ENH_BANK_KEY  = 8'hBF;
  localparam int         FCR_ENABLE    = 0;
  localparam int         FCR_RX_CLEAR  = 1;
  localparam int         FCR_TX_CLEAR  = 2;
  localparam int         FCR_DMA_MODE  = 3;
  localparam int         LCR_DIV_SEL   = 7;
  localparam int         LCR_BREAK     = 6;
  localparam int         LCR_PAR_FORCE = 5;
  localparam int         LCR_PAR_EVEN  = 4;
  localparam int         LCR_PAR_EN    = 3;
  localparam int         LCR_STOP_LONG = 2;
  localparam int         MCR_PRESCALE  = 7;
  localparam int         MCR_BANK_TT   = 6;
  localparam int         MCR_LOOPBACK  = 4;
  localparam int         MCR_RDY_EN    = 2;
  localparam int         EFR_ENHANCED  = 4;
  localparam logic [7:0] IER_ENH_MASK  = 8'hF0;
  localparam logic [7:0] MCR_ENH_MASK  = 8'hE0;
  localparam logic [7:0] FCR_ENH_MASK  = 8'h30;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [3:0] IIR_NO_IRQ    = 4'h1;

  // Trigger levels, indexed by the two-bit field
  localparam logic [CNT_W-1:0] TX_TRIG [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
  localparam logic [CNT_W-1:0] RX_TRIG [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};

  // Bit timing in 16x sample ticks
  localparam logic [5:0] SAMP_MID   = 6'h07;
  localparam logic [5:0] SAMP_LAST  = 6'h0F;
  localparam logic [5:0] STOP_HALF  = 6'h17;
  localparam logic [5:0] STOP_TWO   = 6'h1F;
  localparam logic [1:0] PRESCALE_4 = 2'h3;

  typedef enum logic [2:0] {
    LN_IDLE   = 3'b000,
    LN_START  = 3'b001,
    LN_DATA   = 3'b010,
    LN_PARITY = 3'b011,
    LN_STOP   = 3'b100
  } line_state_type;

  typedef struct packed {
    logic       chan_sel_n;
    logic       rd_stb;
    logic       wr_stb;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_req_type;

  typedef struct packed {
    logic [7:0]       irq_enable_mask, char_format_control, handshake_pin_control, scratch_byte, dll, baud_divisor_high, enhanced_features;
    logic [7:0]       resume_char_one, resume_char_two, pause_char_one, pause_char_two, flow_halt_resume_levels, fifo_threshold_levels;
    logic             fifo_en, dma_mode;
    logic [1:0]       tx_trig, rx_trig;
    logic [PTR_W-1:0] rx_wp, rx_rp, tx_wp, tx_rp;
    logic [CNT_W-1:0] rx_cnt, rx_err_cnt, tx_cnt;
    logic             overrun;
    logic [1:0]       pre_cnt;
    logic [15:0]      div_cnt;
    logic             tick;
    line_state_type   rx_st, tx_st;
    logic [5:0]       rx_samp, tx_samp;
    logic [2:0]       rx_bits, tx_bits;
    logic [7:0]       rx_shift, tx_shift;
    logic             rx_par_err, rx_armed, tx_par, tx_line;
    logic [7:0]       rd_data;
    logic             tx_out, rx_ready_n, tx_ready_n;
  } chan_state_type;

endpackage

// ### rtl/uart_channel_regs.sv
// One serial channel: host register map, 64-entry receive and transmit FIFOs, shifters
`timescale 1ns/1ps

module uart_channel_regs
  import uart_regs_pkg::*;
#(
  parameter int CHAN_INDEX = 0
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Host register access
  input  wire uart_regs_pkg::host_req_type host,
  output logic [7:0]                 rd_data,
  // Serial line
  input  wire logic                  rx_in,
  output logic                       tx_out,
  // DMA ready signalling
  output logic                       rx_ready_n,
  output logic                       tx_ready_n,
  // Ready status of all four channels
  input  wire logic [3:0]            peer_rx_ready,
  input  wire logic [3:0]            peer_tx_ready
);
  import uart_regs_pkg::*;

  chan_state_type   s;
  chan_state_type   n;
  logic [ENTRY_W-1:0] rx_mem [FIFO_DEPTH];
  logic [7:0]       tx_mem [FIFO_DEPTH];

  logic             rd, wr, enh, bank_div, bank_bf, bank_tt, rdy_vis;
  logic             rx_line, rx_push, rx_push_ok, rx_pop, rx_clr;
  logic             tx_push, tx_push_ok, tx_pop, tx_clr, fcr_wr;
  logic [ENTRY_W-1:0] rx_entry, rx_top;
  logic [CNT_W-1:0] cap;
  logic [2:0]       wl_last;
  logic [5:0]       stop_last;
  logic [15:0]      divisor;
  logic [7:0]       rd_val, dmask, rdy_byte;
  logic [3:0]       own_rx, own_tx;

  function automatic logic [7:0] word_mask(input logic [1:0] len);
    return 8'hFF >> (2'h3 - len);
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] char_format_control);
    if (char_format_control[LCR_PAR_FORCE]) begin
      return ~char_format_control[LCR_PAR_EVEN];
    end
    return char_format_control[LCR_PAR_EVEN] ? ^d : ~^d;
  endfunction

  assign rx_top = rx_mem[s.rx_rp];

  always_comb begin
    n          = s;
    rd         = host.rd_stb & ~host.chan_sel_n;
    wr         = host.wr_stb & ~host.chan_sel_n;
    enh        = s.enhanced_features[EFR_ENHANCED];
    bank_bf    = (s.char_format_control == ENH_BANK_KEY);
    bank_div   = s.char_format_control[LCR_DIV_SEL];
    bank_tt    = enh & s.handshake_pin_control[MCR_BANK_TT] & ~bank_bf;
    rdy_vis    = ~host.chan_sel_n & s.handshake_pin_control[MCR_RDY_EN] & ~s.handshake_pin_control[MCR_LOOPBACK];
    cap        = s.fifo_en ? CAP_FIFO : CAP_ONE;
    wl_last    = 3'h4 + {1'b0, s.char_format_control[1:0]};
    dmask      = word_mask(s.char_format_control[1:0]);
    divisor    = {s.baud_divisor_high, s.dll};
    stop_last  = ~s.char_format_control[LCR_STOP_LONG] ? SAMP_LAST : (s.char_format_control[1:0] == 2'h0) ? STOP_HALF : STOP_TWO;
    rx_line    = s.handshake_pin_control[MCR_LOOPBACK] ? s.tx_line : rx_in;
    rx_push    = 1'b0;
    rx_entry   = '0;
    rx_pop     = 1'b0;
    rx_clr     = 1'b0;
    tx_push    = 1'b0;
    tx_pop     = 1'b0;
    tx_clr     = 1'b0;
    fcr_wr     = 1'b0;
    rd_val     = REG_RESET;
    own_rx     = 4'h0;
    own_tx     = 4'h0;
    own_rx[CHAN_INDEX[1:0]] = ~s.rx_ready_n;
    own_tx[CHAN_INDEX[1:0]] = ~s.tx_ready_n;
    rdy_byte   = {own_rx, own_tx};
    for (int i = 0; i < 4; i++) begin
      if (i != CHAN_INDEX) begin
        rdy_byte[4 + i] = peer_rx_ready[i];
        rdy_byte[i]     = peer_tx_ready[i];
      end
    end

    // Host writes
    if (wr) begin
      unique case (host.addr)
        OFS_DATA: begin
          if (bank_div) begin
            n.dll = host.wdata;
          end else begin
            tx_push = 1'b1;
          end
        end
        OFS_IRQ_EN: begin
          if (bank_div) begin
            n.baud_divisor_high = host.wdata;
          end else begin
            n.irq_enable_mask = enh ? host.wdata : (s.irq_enable_mask & IER_ENH_MASK) | (host.wdata & ~IER_ENH_MASK);
          end
        end
        OFS_FIFO_CTL: begin
          if (bank_bf) begin
            n.enhanced_features = host.wdata;
          end else begin
            fcr_wr = 1'b1;
          end
        end
        OFS_FORMAT: n.char_format_control = host.wdata;
        OFS_PIN_CTL: begin
          if (bank_bf) begin
            n.resume_char_one = host.wdata;
          end else begin
            n.handshake_pin_control = enh ? host.wdata : (s.handshake_pin_control & MCR_ENH_MASK) | (host.wdata & ~MCR_ENH_MASK);
          end
        end
        OFS_LINE_STATE: n.resume_char_two = bank_bf ? host.wdata : s.resume_char_two;
        OFS_PIN_STATE: begin
          if (bank_bf) begin
            n.pause_char_one = host.wdata;
          end else if (bank_tt) begin
            n.flow_halt_resume_levels = host.wdata;
          end
        end
        OFS_SCRATCH: begin
          if (bank_bf) begin
            n.pause_char_two = host.wdata;
          end else if (bank_tt) begin
            n.fifo_threshold_levels = host.wdata;
          end else begin
            n.scratch_byte = host.wdata;
          end
        end
      endcase
    end

    // FIFO setup register: only side effects; only the enable bit reads back, in bits 7:6 at this offset
    if (fcr_wr) begin
      n.fifo_en  = host.wdata[FCR_ENABLE];
      // Mode change also empties both, so pointers never straddle the two depths
      rx_clr     = host.wdata[FCR_RX_CLEAR] | (host.wdata[FCR_ENABLE] != s.fifo_en);
      tx_clr     = host.wdata[FCR_TX_CLEAR] | (host.wdata[FCR_ENABLE] != s.fifo_en);
      n.dma_mode = host.wdata[FCR_DMA_MODE];
      n.rx_trig  = host.wdata[7:6];
      if (enh) begin
        n.tx_trig = host.wdata[5:4];
      end
    end

    // Host reads
    if (rd) begin
      unique case (host.addr)
        OFS_DATA: begin
          rd_val = bank_div ? s.dll : rx_top[7:0];
          rx_pop = ~bank_div & (s.rx_cnt != '0);
        end
        OFS_IRQ_EN:   rd_val = bank_div ? s.baud_divisor_high : s.irq_enable_mask;
        OFS_FIFO_CTL: rd_val = bank_bf ? s.enhanced_features : {s.fifo_en, s.fifo_en, 2'h0, IIR_NO_IRQ};
        OFS_FORMAT:   rd_val = s.char_format_control;
        OFS_PIN_CTL:  rd_val = bank_bf ? s.resume_char_one : s.handshake_pin_control;
        OFS_LINE_STATE: begin
          if (bank_bf) begin
            rd_val = s.resume_char_two;
          end else begin
            rd_val = {s.rx_err_cnt != '0, (s.tx_cnt == '0) && (s.tx_st == LN_IDLE), s.tx_cnt == '0,
                      rx_top[10:8], s.overrun, s.rx_cnt != '0};
            n.overrun = 1'b0;
          end
        end
        OFS_PIN_STATE: rd_val = bank_bf ? s.pause_char_one : bank_tt ? s.flow_halt_resume_levels : REG_RESET;
        OFS_SCRATCH:  rd_val = bank_bf ? s.pause_char_two : bank_tt ? s.fifo_threshold_levels : rdy_vis ? rdy_byte : s.scratch_byte;
      endcase
      n.rd_data = rd_val;
    end

    // Baud tick at 16x bit rate, optional divide by four ahead of the divisor
    n.tick = 1'b0;
    if (s.pre_cnt == (s.handshake_pin_control[MCR_PRESCALE] ? PRESCALE_4 : 2'h0)) begin
      n.pre_cnt = 2'h0;
      if (s.div_cnt == 16'h0000) begin
        n.div_cnt = (divisor == 16'h0000) ? 16'h0000 : 16'(divisor - 16'h0001);
        n.tick    = 1'b1;
      end else begin
        n.div_cnt = 16'(s.div_cnt - 16'h0001);
      end
    end else begin
      n.pre_cnt = 2'(s.pre_cnt + 2'h1);
    end

    // Receive shifter
    if (s.tick) begin
      n.rx_samp = 6'(s.rx_samp + 6'h01);
      unique case (s.rx_st)
        LN_IDLE: begin
          n.rx_samp = 6'h00;
          // A held-low line after a break must rise before another start is seen
          if (rx_line) begin
            n.rx_armed = 1'b1;
          end else if (s.rx_armed) begin
            n.rx_st = LN_START;
          end
        end
        LN_START: begin
          if (s.rx_samp == SAMP_MID) begin
            n.rx_samp    = 6'h00;
            n.rx_bits    = 3'h0;
            n.rx_par_err = 1'b0;
            n.rx_st      = rx_line ? LN_IDLE : LN_DATA;
          end
        end
        LN_DATA: begin
          if (s.rx_samp == SAMP_LAST) begin
            n.rx_samp  = 6'h00;
            n.rx_shift = {rx_line, s.rx_shift[7:1]};
            n.rx_bits  = 3'(s.rx_bits + 3'h1);
            if (s.rx_bits == wl_last) begin
              n.rx_shift = {rx_line, s.rx_shift[7:1]} >> (3'h7 - wl_last);
              n.rx_st    = s.char_format_control[LCR_PAR_EN] ? LN_PARITY : LN_STOP;
            end
          end
        end
        LN_PARITY: begin
          if (s.rx_samp == SAMP_LAST) begin
            n.rx_samp    = 6'h00;
            n.rx_par_err = rx_line != par_bit(s.rx_shift & dmask, s.char_format_control);
            n.rx_st      = LN_STOP;
          end
        end
        LN_STOP: begin
          if (s.rx_samp == SAMP_LAST) begin
            rx_push    = 1'b1;
            rx_entry   = {~rx_line & (s.rx_shift == 8'h00), ~rx_line, s.rx_par_err, s.rx_shift};
            n.rx_armed = rx_line;
            n.rx_st    = LN_IDLE;
          end
        end
        default: n.rx_st = LN_IDLE;
      endcase
    end

    // Receive FIFO bookkeeping
    rx_push_ok = rx_push & (s.rx_cnt < cap);
    if (rx_push & ~rx_push_ok) begin
      n.overrun = 1'b1;
    end
    if (rx_push_ok) begin
      n.rx_wp = s.fifo_en ? PTR_W'(s.rx_wp + 6'h01) : '0;
    end
    if (rx_pop) begin
      n.rx_rp = s.fifo_en ? PTR_W'(s.rx_rp + 6'h01) : '0;
    end
    n.rx_cnt     = 7'(s.rx_cnt + {6'h00, rx_push_ok} - {6'h00, rx_pop});
    n.rx_err_cnt = 7'(s.rx_err_cnt + {6'h00, rx_push_ok & |rx_entry[10:8]}
                      - {6'h00, rx_pop & |rx_top[10:8]});
    if (rx_clr) begin
      n.rx_wp      = '0;
      n.rx_rp      = '0;
      n.rx_cnt     = '0;
      n.rx_err_cnt = '0;
    end

    // Transmit shifter
    if (s.tick) begin
      n.tx_samp = 6'(s.tx_samp + 6'h01);
      unique case (s.tx_st)
        LN_IDLE: begin
          n.tx_samp = 6'h00;
          if (s.tx_cnt != '0) begin
            tx_pop     = 1'b1;
            n.tx_shift = tx_mem[s.tx_rp];
            n.tx_par   = par_bit(tx_mem[s.tx_rp] & dmask, s.char_format_control);
            n.tx_line  = 1'b0;
            n.tx_st    = LN_START;
          end
        end
        LN_START: begin
          if (s.tx_samp == SAMP_LAST) begin
            n.tx_samp = 6'h00;
            n.tx_bits = 3'h0;
            n.tx_line = s.tx_shift[0];
            n.tx_st   = LN_DATA;
          end
        end
        LN_DATA: begin
          if (s.tx_samp == SAMP_LAST) begin
            n.tx_samp  = 6'h00;
            n.tx_bits  = 3'(s.tx_bits + 3'h1);
            n.tx_shift = s.tx_shift >> 1;
            n.tx_line  = s.tx_shift[1];
            if (s.tx_bits == wl_last) begin
              n.tx_line = s.char_format_control[LCR_PAR_EN] ? s.tx_par : 1'b1;
              n.tx_st   = s.char_format_control[LCR_PAR_EN] ? LN_PARITY : LN_STOP;
            end
          end
        end
        LN_PARITY: begin
          if (s.tx_samp == SAMP_LAST) begin
            n.tx_samp = 6'h00;
            n.tx_line = 1'b1;
            n.tx_st   = LN_STOP;
          end
        end
        LN_STOP: begin
          if (s.tx_samp == stop_last) begin
            n.tx_st = LN_IDLE;
          end
        end
        default: n.tx_st = LN_IDLE;
      endcase
    end

    // Transmit FIFO bookkeeping
    tx_push_ok = tx_push & (s.tx_cnt < cap);
    if (tx_push_ok) begin
      n.tx_wp = s.fifo_en ? PTR_W'(s.tx_wp + 6'h01) : '0;
    end
    if (tx_pop) begin
      n.tx_rp = s.fifo_en ? PTR_W'(s.tx_rp + 6'h01) : '0;
    end
    n.tx_cnt = 7'(s.tx_cnt + {6'h00, tx_push_ok} - {6'h00, tx_pop});
    if (tx_clr) begin
      n.tx_wp  = '0;
      n.tx_rp  = '0;
      n.tx_cnt = '0;
    end

    // Pins and DMA ready; mode 1 only means something with FIFOs on
    n.tx_out = s.handshake_pin_control[MCR_LOOPBACK] | (n.tx_line & ~s.char_format_control[LCR_BREAK]);
    if (s.dma_mode & n.fifo_en) begin
      n.rx_ready_n = n.rx_cnt < RX_TRIG[n.rx_trig];
      n.tx_ready_n = (CAP_FIFO - n.tx_cnt) < TX_TRIG[n.tx_trig];
    end else begin
      n.rx_ready_n = n.rx_cnt == '0;
      n.tx_ready_n = n.tx_cnt != '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s            <= '0;
      s.tx_line    <= 1'b1;
      s.tx_out     <= 1'b1;
      s.rx_ready_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Data arrays carry no reset; occupancy is tracked by the counters
  always_ff @(posedge core_clk) begin
    if (rx_push_ok & ~rx_clr) begin
      rx_mem[s.fifo_en ? s.rx_wp : '0] <= rx_entry;
    end
    if (tx_push_ok) begin
      tx_mem[s.fifo_en ? s.tx_wp : '0] <= host.wdata;
    end
  end

  assign rd_data    = s.rd_data;
  assign tx_out     = s.tx_out;
  assign rx_ready_n = s.rx_ready_n;
  assign tx_ready_n = s.tx_ready_n;

endmodule

// ### tb/uart_channel_regs_props.sv
// Property checker for one serial channel's register map, bound to the channel
`timescale 1ns/1ps
module uart_channel_regs_chk
  import uart_regs_pkg::*;
(
  // Clock and reset
  input wire logic                         core_clk,
  input wire logic                         rst,
  // Host side
  input wire uart_regs_pkg::host_req_type host,
  input wire logic [7:0]                   rd_data,
  // Ready outputs and peer status
  input wire logic                         rx_ready_n,
  input wire logic                         tx_ready_n,
  input wire logic [3:0]                   peer_rx_ready,
  input wire logic [3:0]                   peer_tx_ready
);
  logic [7:0] fmt_r, div_lo_r, irq_mask_r, pin_ctl_r, resume1_r;
  logic       enh_r, fifo_on_r;
  wire        wr   = !host.chan_sel_n && host.wr_stb;
  wire        rd   = !host.chan_sel_n && host.rd_stb;
  wire        bank = fmt_r == ENH_BANK_KEY;

  // Shadow of the writable state so read data can be predicted
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {fmt_r, div_lo_r, irq_mask_r, pin_ctl_r, resume1_r, enh_r, fifo_on_r} <= '0;
    end else if (wr) begin
      case (host.addr)
        OFS_DATA: if (fmt_r[LCR_DIV_SEL]) div_lo_r <= host.wdata;
        OFS_IRQ_EN: if (!fmt_r[LCR_DIV_SEL]) irq_mask_r <= enh_r ? host.wdata : {irq_mask_r[7:4], host.wdata[3:0]};
        OFS_FIFO_CTL: if (bank) enh_r <= host.wdata[EFR_ENHANCED]; else fifo_on_r <= host.wdata[FCR_ENABLE];
        OFS_FORMAT: fmt_r <= host.wdata;
        OFS_PIN_CTL: if (bank) resume1_r <= host.wdata; else pin_ctl_r <= enh_r ? host.wdata : {pin_ctl_r[7:5], host.wdata[4:0]};
        default: ;
      endcase
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_iir_mirror;
    rd && host.addr == OFS_FIFO_CTL && !bank |=> rd_data == {{2{fifo_on_r}}, 2'b00, IIR_NO_IRQ};
  endproperty
  a_iir_mirror: assert property (p_iir_mirror) else $error("source id read mismatch");
  // Peer bits 3:1 only: the bench runs channel index 0
  property p_ready_byte;
    rd && host.addr == OFS_SCRATCH && !bank && pin_ctl_r[MCR_RDY_EN] && !pin_ctl_r[MCR_LOOPBACK]
      && !(enh_r && pin_ctl_r[MCR_BANK_TT])
      |=> rd_data[7:5] == $past(peer_rx_ready[3:1]) && rd_data[3:1] == $past(peer_tx_ready[3:1]);
  endproperty
  a_ready_byte: assert property (p_ready_byte) else $error("ready byte mismatch");
  property p_irq_mask_hold;
    rd && host.addr == OFS_IRQ_EN && !fmt_r[LCR_DIV_SEL] |=> rd_data == irq_mask_r;
  endproperty
  a_irq_mask_hold: assert property (p_irq_mask_hold) else $error("enhanced bits changed");
  property p_div_bank;
    rd && host.addr == OFS_DATA && fmt_r[LCR_DIV_SEL] |=> rd_data == div_lo_r;
  endproperty
  a_div_bank: assert property (p_div_bank) else $error("divisor byte mismatch");
  property p_offset4;
    rd && host.addr == OFS_PIN_CTL |=> rd_data == (bank ? resume1_r : pin_ctl_r);
  endproperty
  a_offset4: assert property (p_offset4) else $error("offset 4 bank mismatch");
  property p_tx_clear;
    wr && host.addr == OFS_FIFO_CTL && !bank && host.wdata[FCR_TX_CLEAR] |=> !tx_ready_n;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx not ready after clear");
  property p_rx_clear;
    wr && host.addr == OFS_FIFO_CTL && !bank && host.wdata[FCR_RX_CLEAR] |=> rx_ready_n;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx ready after clear");
  property p_rd_hold;
    !rd |=> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
endmodule

bind uart_channel_regs uart_channel_regs_chk u_chk (
  .core_clk(core_clk), .rst(rst), .host(host), .rd_data(rd_data), .rx_ready_n(rx_ready_n),
  .tx_ready_n(tx_ready_n), .peer_rx_ready(peer_rx_ready), .peer_tx_ready(peer_tx_ready));

// ### tb/host_bus_model.sv
// Host processor model: register reads and writes on the channel's parallel bus
`timescale 1ns/1ps
module host_bus_model
  import uart_regs_pkg::*;
(
  input  wire logic                   core_clk,
  output uart_regs_pkg::host_req_type host,
  input  wire logic [7:0]             rd_data
);
  initial host = '{1'b1, 1'b0, 1'b0, 3'h0, 8'h00};

  // Deselected bus shows inverted address and data, never the last value
  task automatic idle_bus;
    host = '{1'b1, 1'b0, 1'b0, ~host.addr, ~host.wdata};
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1;
    host = '{1'b0, 1'b0, 1'b1, a, v};
    @(posedge core_clk);
    #1;
    idle_bus();
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk);
    #1;
    host = '{1'b0, 1'b1, 1'b0, a, host.wdata};
    @(posedge core_clk);
    #1;
    v = rd_data;
    idle_bus();
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for one serial channel's register map and FIFOs
`timescale 1ns/1ps
module tb_top;
  import uart_regs_pkg::*;
  localparam int TX_LEVEL [4] = '{8, 16, 32, 56};
  logic         core_clk;
  logic         rst;
  host_req_type host;
  logic [7:0]   rd_data;
  logic         tx_out;
  logic         rx_ready_n;
  logic         tx_ready_n;
  logic [3:0]   peer_rx_ready;
  logic [3:0]   peer_tx_ready;
  logic [7:0]   d;
  int           failures;
  int           num_checks;

  // Serial line looped back outside the channel
  uart_channel_regs #(.CHAN_INDEX(0)) dut (
    .core_clk(core_clk), .rst(rst), .host(host), .rd_data(rd_data), .rx_in(tx_out), .tx_out(tx_out),
    .rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n), .peer_rx_ready(peer_rx_ready),
    .peer_tx_ready(peer_tx_ready));
  host_bus_model u_host (.core_clk(core_clk), .host(host), .rd_data(rd_data));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic read_check(input logic [2:0] a, input logic [7:0] mask, input logic [7:0] exp);
    u_host.rd(a, d);
    chk(d & mask, exp);
  endtask

  task automatic burst(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++)
      u_host.wr(OFS_DATA, base + 8'(i));
  endtask

  // Receiver pushes at the middle of the stop bit, about half a bit before the transmitter idles
  task automatic wait_idle;
    for (int i = 0; i < 2000; i++) begin
      u_host.rd(OFS_LINE_STATE, d);
      if (d[6] === 1'b1) begin
        repeat (40) @(posedge core_clk);
        return;
      end
    end
    failures++;
    end_sim();
  endtask

  initial begin
    rst = 1'b1;
    peer_rx_ready = 4'hA;
    peer_tx_ready = 4'h5;
    failures = 0;
    num_checks = 0;
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk({7'h00, tx_ready_n}, 8'h00);
    chk({7'h00, rx_ready_n}, 8'h01);
    read_check(OFS_FIFO_CTL, 8'hFF, 8'h01);
    u_host.wr(OFS_FORMAT, 8'h83);
    u_host.wr(OFS_DATA, 8'h02);
    read_check(OFS_DATA, 8'hFF, 8'h02);
    u_host.wr(OFS_FORMAT, 8'h03);
    u_host.wr(OFS_IRQ_EN, 8'hF5);
    read_check(OFS_IRQ_EN, 8'hFF, 8'h05);
    u_host.wr(OFS_FIFO_CTL, 8'h39);
    read_check(OFS_FIFO_CTL, 8'hFF, 8'hC1);
    // Trigger field locked, so level stays at 8 spaces
    burst(50, 8'h40);
    chk({7'h00, tx_ready_n}, 8'h00);
    u_host.wr(OFS_FORMAT, ENH_BANK_KEY);
    u_host.wr(OFS_FIFO_CTL, 8'h10);
    u_host.wr(OFS_PIN_CTL, 8'h5A);
    read_check(OFS_PIN_CTL, 8'hFF, 8'h5A);
    u_host.wr(OFS_FORMAT, 8'h03);
    read_check(OFS_PIN_CTL, 8'hFF, 8'h00);
    u_host.wr(OFS_IRQ_EN, 8'hF5);
    read_check(OFS_IRQ_EN, 8'hFF, 8'hF5);
    // Shifter may hold one byte, so counts straddle the level by one
    for (int k = 0; k < 4; k++) begin
      u_host.wr(OFS_FIFO_CTL, {2'b00, 2'(k), 4'hD});
      burst(64 - TX_LEVEL[k], 8'h00);
      chk({7'h00, tx_ready_n}, 8'h00);
      burst(2, 8'h80);
      chk({7'h00, tx_ready_n}, 8'h01);
    end
    burst(70, 8'h00);
    chk({7'h00, tx_ready_n}, 8'h01);
    read_check(OFS_LINE_STATE, 8'h20, 8'h00);
    u_host.wr(OFS_FIFO_CTL, 8'h0D);
    chk({7'h00, tx_ready_n}, 8'h00);
    read_check(OFS_LINE_STATE, 8'h20, 8'h20);
    u_host.wr(OFS_PIN_CTL, 8'h40);
    u_host.wr(OFS_SCRATCH, 8'h3C);
    read_check(OFS_SCRATCH, 8'hFF, 8'h3C);
    // Own transmit bit set: transmit FIFO just emptied
    u_host.wr(OFS_PIN_CTL, 8'h04);
    read_check(OFS_SCRATCH, 8'hEF, 8'hA5);
    u_host.wr(OFS_PIN_CTL, 8'h00);
    read_check(OFS_SCRATCH, 8'hFF, 8'h00);
    wait_idle();
    u_host.wr(OFS_FIFO_CTL, 8'h07);
    chk({7'h00, rx_ready_n}, 8'h01);
    burst(3, 8'hA5);
    wait_idle();
    chk({7'h00, rx_ready_n}, 8'h00);
    for (int i = 0; i < 3; i++)
      read_check(OFS_DATA, 8'hFF, 8'hA5 + 8'(i));
    read_check(OFS_LINE_STATE, 8'h81, 8'h00);
    // Receive level 8 in mode 1: seven stored is not enough
    u_host.wr(OFS_FIFO_CTL, 8'h0F);
    burst(7, 8'h30);
    wait_idle();
    chk({7'h00, rx_ready_n}, 8'h01);
    burst(1, 8'h37);
    wait_idle();
    chk({7'h00, rx_ready_n}, 8'h00);
    u_host.wr(OFS_FIFO_CTL, 8'h00);
    burst(1, 8'h11);
    wait_idle();
    burst(1, 8'h22);
    // One character time at divisor 2 plus margin; polling status would clear overrun
    repeat (400) @(posedge core_clk);
    read_check(OFS_LINE_STATE, 8'h03, 8'h03);
    read_check(OFS_DATA, 8'hFF, 8'h11);
    read_check(OFS_LINE_STATE, 8'h01, 8'h00);
    // Break held past one character: zero byte with break and framing flags
    u_host.wr(OFS_FORMAT, 8'h43);
    repeat (400) @(posedge core_clk);
    u_host.wr(OFS_FORMAT, 8'h03);
    read_check(OFS_LINE_STATE, 8'h9F, 8'h99);
    read_check(OFS_DATA, 8'hFF, 8'h00);
    read_check(OFS_LINE_STATE, 8'h80, 8'h00);
    end_sim();
  end
endmodule
